// *** crs_top.sv ***
// Readback selection and convert-then-read sequencing of one chain part.
// Assumes serial pins and convert_start_n come from outside the core clock.
// Functional notes
// - Nonzero read address returns that register.
// - Zero read address returns results per D13:D12.
// - Select 12, 9, 6 results or off.
// - D15:D12 zero converts, returns all twelve.
// - D14,D12 set: six voltages, three temperatures.
// - D15,D13 set: six voltages only.
// - D13,D12 both set disables read output.
// - D15:D14 choose conversions per cycle.
// - Readback uses last complete conversion set.
// - Convert start falling or chip select rising.
// - Read address resets to zero.
// - Write frame layout; check over D31:D11.
// - Register readback check over D31:D10.
`timescale 1ns/1ps
`default_nettype none
module crs_top #(
   parameter int FIFO_DEPTH = crs_pkg::FIFO_DEPTH,
   parameter int CONV_CYC = crs_pkg::CONV_CYC
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic convert_start_n,
   input wire logic [4:0] dev_addr,
   input wire logic [crs_pkg::CH_NUM*crs_pkg::RES_W-1:0] adc_result,
   output logic sdo,
   output logic conv_busy,
   output logic frame_crc_err,
   output logic [5:0] read_addr,
   output logic [7:0] control_hi
);
   typedef struct packed {
      logic [1:0] cs_sy;
      logic [1:0] sck_sy;
      logic [1:0] sdi_sy;
      logic [1:0] cnv_sy;
      logic cs_q;
      logic sck_q;
      logic cnv_q;
      logic [4:0] dev_m;
      logic [4:0] dev;
      logic [5:0] rd_addr;
      logic [7:0] ctrl;
      logic [31:0] rx;
      logic [31:0] tx;
      logic [4:0] bitcnt;
      logic fresh;
      logic sdo;
      logic crc_err;
      logic busy;
      logic [15:0] timer;
      logic [1:0] conv_mode;
      logic [crs_pkg::CH_NUM-1:0][crs_pkg::RES_W-1:0] res;
      logic refill;
      logic fill;
      logic [3:0] idx;
   } crs_state_s;

   crs_state_s s;
   crs_state_s next_s;

   logic f_clr;
   logic f_push;
   logic f_in_ready;
   logic [31:0] f_in_data;
   logic f_out_valid;
   logic f_pop;
   logic [31:0] f_out_data;

   crs_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .clr(f_clr),
      .in_valid(f_push),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_pop),
      .out_data(f_out_data)
   );

   function automatic logic [4:0] conv_count(input logic [1:0] m);
      case (m)
         2'b00: return 5'd12;
         2'b01: return 5'd9;
         2'b10: return 5'd6;
         default: return 5'd1;
      endcase
   endfunction

   function automatic logic [11:0] conv_mask(input logic [1:0] m);
      case (m)
         2'b00: return crs_pkg::MASK_12;
         2'b01: return crs_pkg::MASK_9;
         2'b10: return crs_pkg::MASK_6;
         default: return 12'h0000;
      endcase
   endfunction

   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic cnv_fall;
   logic [31:0] w;
   logic [4:0] total;
   logic [3:0] ch;
   logic [7:0] regval;
   logic [31:0] word;
   logic [1:0] sel;

   always_comb begin
      next_s = s;
      f_clr = 1'b0;
      f_push = 1'b0;
      f_pop = 1'b0;
      w = 32'h0000_0000;
      word = 32'h0000_0000;
      regval = 8'h00;
      ch = 4'h0;
      sel = s.ctrl[crs_pkg::C_SEL_LSB +: 2];

      next_s.cs_sy = {s.cs_sy[0], cs_n};
      next_s.sck_sy = {s.sck_sy[0], sclk};
      next_s.sdi_sy = {s.sdi_sy[0], sdi};
      next_s.cnv_sy = {s.cnv_sy[0], convert_start_n};
      next_s.cs_q = s.cs_sy[1];
      next_s.sck_q = s.sck_sy[1];
      next_s.cnv_q = s.cnv_sy[1];
      next_s.dev_m = dev_addr;
      next_s.dev = s.dev_m;

      cs_fall = s.cs_q & ~s.cs_sy[1];
      cs_rise = ~s.cs_q & s.cs_sy[1];
      sck_rise = ~s.sck_q & s.sck_sy[1] & ~s.cs_sy[1];
      sck_fall = s.sck_q & ~s.sck_sy[1] & ~s.cs_sy[1];
      cnv_fall = s.cnv_q & ~s.cnv_sy[1];
      next_s.crc_err = 1'b0;

      // Read-off silences register readback too; nonzero read address gives one word
      if (sel == crs_pkg::CRS_SEL_OFF) begin
         total = 5'd0;
      end else if (s.rd_addr != 6'h00) begin
         total = 5'd1;
      end else begin
         case (sel)
            crs_pkg::CRS_SEL_12: total = 5'd12;
            crs_pkg::CRS_SEL_9: total = 5'd9;
            crs_pkg::CRS_SEL_6: total = 5'd6;
            default: total = 5'd0;
         endcase
      end

      // Serial frame: sample on rising, shift out on falling
      if (cs_fall) begin
         next_s.tx = f_out_valid ? f_out_data : 32'h0000_0000;
         f_pop = f_out_valid;
         next_s.bitcnt = 5'd0;
         next_s.fresh = 1'b0;
      end
      if (sck_rise) begin
         next_s.rx = {s.rx[30:0], s.sdi_sy[1]};
         next_s.bitcnt = s.bitcnt + 5'd1;
         if (s.bitcnt == 5'd31) begin
            w = next_s.rx;
            if (crs_pkg::crs_crc8(w, crs_pkg::WR_CRC_BITS) == w[crs_pkg::F_WCRC_LSB +: 8]) begin
               if (w[crs_pkg::F_ALL] || w[crs_pkg::F_DEV_LSB +: 5] == s.dev) begin
                  if (w[crs_pkg::F_REG_LSB +: 6] == crs_pkg::REG_READ) begin
                     next_s.rd_addr = w[crs_pkg::F_DAT_LSB + 2 +: 6];
                  end else if (w[crs_pkg::F_REG_LSB +: 6] == crs_pkg::REG_CTRL_HI) begin
                     next_s.ctrl = w[crs_pkg::F_DAT_LSB +: 8];
                  end
               end
            end else begin
               next_s.crc_err = 1'b1;
            end
            next_s.tx = f_out_valid ? f_out_data : 32'h0000_0000;
            f_pop = f_out_valid;
            next_s.fresh = 1'b1;
         end
      end
      if (sck_fall) begin
         if (s.fresh) begin
            next_s.fresh = 1'b0;
         end else begin
            next_s.tx = {s.tx[30:0], 1'b0};
         end
      end
      next_s.sdo = ~s.cs_sy[1] & next_s.tx[31];

      // Conversion cycle; the whole set is latched in one edge on completion
      if (!s.busy && (cnv_fall || cs_rise)) begin
         next_s.busy = 1'b1;
         next_s.conv_mode = s.ctrl[crs_pkg::C_CONV_LSB +: 2];
         next_s.timer = 16'(CONV_CYC * int'(conv_count(s.ctrl[crs_pkg::C_CONV_LSB +: 2])));
      end else if (s.busy) begin
         if (s.timer <= 16'h0001) begin
            next_s.busy = 1'b0;
            next_s.refill = 1'b1;
            for (int c = 0; c < crs_pkg::CH_NUM; c++) begin
               if (conv_mask(s.conv_mode)[c]) begin
                  next_s.res[c] = adc_result[c*crs_pkg::RES_W +: crs_pkg::RES_W];
               end
            end
         end else begin
            next_s.timer = s.timer - 16'h0001;
         end
      end

      // Readback builder; waits for chip select high so a frame never tears
      if (cs_rise) begin
         next_s.refill = 1'b1;
      end
      if (s.refill && s.cs_sy[1] && !cs_rise) begin
         f_clr = 1'b1;
         // Completion in this same cycle wins over the clear
         next_s.refill = s.busy && (s.timer <= 16'h0001);
         next_s.idx = 4'h0;
         next_s.fill = (total != 5'd0);
      end else if (s.fill && f_in_ready) begin
         if (s.rd_addr != 6'h00) begin
            if (s.rd_addr == crs_pkg::REG_READ) begin
               regval = {s.rd_addr, 2'b00};
            end else if (s.rd_addr == crs_pkg::REG_CTRL_HI) begin
               regval = s.ctrl;
            end
            word = {s.dev, s.rd_addr, regval, 2'b00, 1'b1, 10'h000};
         end else begin
            if (sel == crs_pkg::CRS_SEL_9 && s.idx >= 4'd6) begin
               ch = 4'((s.idx << 1) - 4'd6);
            end else begin
               ch = s.idx;
            end
            word = {s.dev, ch, s.res[ch], 1'b1, 10'h000};
         end
         word[crs_pkg::F_RCRC_LSB +: 8] = crs_pkg::crs_crc8(word, crs_pkg::RD_CRC_BITS);
         f_push = 1'b1;
         next_s.idx = s.idx + 4'd1;
         if ({1'b0, s.idx} == total - 5'd1) begin
            next_s.fill = 1'b0;
         end
      end
      f_in_data = word;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
         s.cs_sy <= 2'b11;
         s.cs_q <= 1'b1;
         s.cnv_sy <= 2'b11;
         s.cnv_q <= 1'b1;
         s.rd_addr <= crs_pkg::RST_READ;
         s.ctrl <= crs_pkg::RST_CTRL_HI;
         s.refill <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign sdo = s.sdo;
   assign conv_busy = s.busy;
   assign frame_crc_err = s.crc_err;
   assign read_addr = s.rd_addr;
   assign control_hi = s.ctrl;
endmodule
`default_nettype wire

// *** crs_pkg.sv ***
// Shared constants for the chain readback select block.
// Assumes a single core clock; no other package is required.
package crs_pkg;
   localparam int CLK_HZ = 10_000_000;
   // Time of one channel conversion; plain default, not a documented figure
   localparam int CONV_NS = 1000;
   localparam int CONV_CYC = (CONV_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int FRAME_BITS = 32;
   localparam int CH_NUM = 12;
   localparam int RES_W = 12;
   localparam int FIFO_DEPTH = 32;

   // Register addresses
   localparam logic [5:0] REG_CTRL_HI = 6'h0D;
   localparam logic [5:0] REG_READ = 6'h1C;
   localparam logic [5:0] RST_READ = 6'h00;
   localparam logic [7:0] RST_CTRL_HI = 8'h00;

   // Frame field positions
   localparam int F_DEV_LSB = 27;
   localparam int F_REG_LSB = 21;
   localparam int F_DAT_LSB = 13;
   localparam int F_ALL = 12;
   localparam int F_WCRC_LSB = 3;
   localparam int F_ACK = 10;
   localparam int F_RCRC_LSB = 2;
   localparam int WR_CRC_BITS = 21;
   localparam int RD_CRC_BITS = 22;

   // Control high byte fields (D15:D14 conversions, D13:D12 readback)
   localparam int C_CONV_LSB = 6;
   localparam int C_SEL_LSB = 4;

   localparam logic [7:0] CRC_POLY = 8'h2F;

   typedef enum logic [1:0] {
      CRS_SEL_12 = 2'b00,
      CRS_SEL_9 = 2'b01,
      CRS_SEL_6 = 2'b10,
      CRS_SEL_OFF = 2'b11
   } crs_sel_e;

   localparam logic [11:0] MASK_12 = 12'h0FFF;
   localparam logic [11:0] MASK_9 = 12'h057F;
   localparam logic [11:0] MASK_6 = 12'h003F;

   // Serial check, most significant covered bit first, register starts at zero
   function automatic logic [7:0] crs_crc8(input logic [31:0] d, input int n);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         if (i >= 32 - n) begin
            fb = d[i] ^ c[7];
            c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
         end
      end
      return c;
   endfunction
endpackage

// *** crs_fifo.sv ***
// Frame word FIFO between the readback builder and the serial shifter.
// Assumes the same clock on both sides; clr drops all contents at once.
`timescale 1ns/1ps
`default_nettype none
module crs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clr,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } crs_fifo_s;

   crs_fifo_s s;
   crs_fifo_s next_s;
   logic full;
   logic empty;

   assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
   assign empty = (s.wp == s.rp);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = s.mem[s.rp[AW-1:0]];

   always_comb begin
      next_s = s;
      if (clr) begin
         next_s.wp = '0;
         next_s.rp = '0;
      end else begin
         if (in_valid && !full) begin
            next_s.mem[s.wp[AW-1:0]] = in_data;
            next_s.wp = s.wp + 1'b1;
         end
         if (out_ready && !empty) begin
            next_s.rp = s.rp + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// *** crs_top_monitor.sv ***
// Port-level checker for the chain readback select block.
// Assumes one core clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module crs_top_monitor #(
   parameter int FIFO_DEPTH = 32,
   parameter int CONV_CYC = 10
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic convert_start_n,
   input wire logic [4:0] dev_addr,
   input wire logic [crs_pkg::CH_NUM*crs_pkg::RES_W-1:0] adc_result,
   input wire logic sdo,
   input wire logic conv_busy,
   input wire logic frame_crc_err,
   input wire logic [5:0] read_addr,
   input wire logic [7:0] control_hi
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   int blen;
   logic [1:0] nsel;
   function automatic int ncount(input logic [1:0] s);
      return s == 2'b00 ? 12 : s == 2'b01 ? 9 : s == 2'b10 ? 6 : 1;
   endfunction
   // Busy length and the count chosen when it started
   always_ff @(posedge core_clk) begin
      if (!rstn || !conv_busy) begin
         blen <= 0;
      end else begin
         blen <= blen + 1;
      end
      if (conv_busy && blen == 0) begin
         nsel <= control_hi[7:6];
      end
   end
   sequence s_cs_idle;
      cs_n [*5];
   endsequence
   sequence s_sclk_rise;
      (!cs_n && !sclk) ##1 (!cs_n && sclk);
   endsequence
   a_reset_clear: assert property (disable iff (1'b0)
      !rstn |=> read_addr == 6'h00 && control_hi == 8'h00 && sdo == 1'b0)
      else $error("outputs not cleared by reset");
   a_sdo_idle: assert property (s_cs_idle |-> sdo == 1'b0)
      else $error("sdo driven while deselected");
   a_sdo_stands: assert property (s_sclk_rise |-> $stable(sdo) ##1 $stable(sdo))
      else $error("sdo moved while sclk high");
   a_busy_on_cs: assert property ($rose(cs_n) && !conv_busy |-> ##[1:6] conv_busy)
      else $error("no conversion after select rise");
   a_busy_on_start: assert property ($fell(convert_start_n) && !conv_busy |-> ##[1:6] conv_busy)
      else $error("no conversion after start fall");
   a_busy_length: assert property ($fell(conv_busy) |-> blen == CONV_CYC * ncount(nsel))
      else $error("conversion length wrong");
   a_err_pulse: assert property (frame_crc_err |=> !frame_crc_err)
      else $error("check error longer than one cycle");
   a_err_no_write: assert property (frame_crc_err |-> $stable(control_hi) && $stable(read_addr))
      else $error("bad frame changed a register");
endmodule
bind crs_top crs_top_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .CONV_CYC(CONV_CYC)) crs_top_monitor_i (
   .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
   .convert_start_n(convert_start_n), .dev_addr(dev_addr), .adc_result(adc_result), .sdo(sdo),
   .conv_busy(conv_busy), .frame_crc_err(frame_crc_err), .read_addr(read_addr), .control_hi(control_hi));
`default_nettype wire

// *** crs_host.sv ***
// Host serial master model: framed 32-bit link, 800 ns sclk.
// Assumes a 100 ns core clock; drives on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module crs_host (
   input wire logic core_clk,
   input wire logic sdo,
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   output logic convert_start_n
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
      convert_start_n = 1'b1;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic open();
      cs_n = 1'b0;
      idle(8);
   endtask
   // Sdo taken as sclk rises, before the part sees that edge
   task automatic word(input logic [31:0] w, output logic [31:0] r);
      for (int i = 31; i >= 0; i--) begin
         sdi = w[i];
         idle(4);
         sclk = 1'b1;
         r[i] = sdo;
         idle(4);
         sclk = 1'b0;
      end
   endtask
   task automatic close();
      idle(4);
      cs_n = 1'b1;
      sdi = ~sdi; // Released line shows no stale bit
      idle(8);
   endtask
   task automatic wr_frame(input logic [31:0] w);
      logic [31:0] r;
      open();
      word(w, r);
      close();
   endtask
   task automatic start();
      convert_start_n = 1'b0;
      idle(8);
      convert_start_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** crs_top_bench.sv ***
// Self-checking bench for the chain readback select block.
// Assumes crs_pkg, crs_top with its FIFO, the host model and the checker.
`timescale 1ns/1ps
`default_nettype none
module crs_top_bench;
   localparam int CC = 2;
   localparam logic [4:0] DEV = 5'h05;
   logic core_clk, rstn, cs_n, sclk, sdi, convert_start_n, sdo, conv_busy, frame_crc_err;
   logic [5:0] read_addr;
   logic [7:0] control_hi;
   logic [crs_pkg::CH_NUM*crs_pkg::RES_W-1:0] adc, lat;
   int mismatches, checks, crc_errs;
   crs_top #(.CONV_CYC(CC)) crs_top_i (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .convert_start_n(convert_start_n), .dev_addr(DEV), .adc_result(adc), .sdo(sdo), .conv_busy(conv_busy),
      .frame_crc_err(frame_crc_err), .read_addr(read_addr), .control_hi(control_hi));
   crs_host crs_host_i (.core_clk(core_clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .convert_start_n(convert_start_n));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (frame_crc_err === 1'b1) crc_errs++;
   function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
      logic [7:0] c = 8'h00;
      for (int i = 31; i > 31 - n; i--) c = {c[6:0], 1'b0} ^ ((d[i] ^ c[7]) ? 8'h2F : 8'h00);
      return c;
   endfunction
   function automatic logic [31:0] wr(input logic [4:0] d, input logic [5:0] a, input logic [7:0] v, input logic all);
      logic [31:0] w = {d, a, v, all, 12'h000};
      w[10:3] = crc8(w, 21);
      return w;
   endfunction
   function automatic logic [31:0] fr(input logic [21:0] h);
      logic [31:0] w = {h, 10'h000};
      w[9:2] = crc8(w, 22);
      return w;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_conv();
      int n;
      for (n = 0; n < 2000 && conv_busy !== 1'b0; n++) @(negedge core_clk);
      if (n == 2000) begin
         mismatches++;
         print_verdict();
      end
      repeat (50) @(negedge core_clk);
   endtask
   // Reads n results plus one surplus word, which must come back empty
   task automatic read_n(input int n, input logic [31:0] exp0);
      logic [31:0] r;
      logic [3:0] ch;
      crs_host_i.open();
      for (int k = 0; k <= n; k++) begin
         ch = (n == 9 && k > 5) ? 4'(2 * k - 6) : 4'(k);
         crs_host_i.word(wr(5'h1F, 6'h00, 8'h00, 1'b0), r);
         if (exp0 !== 32'h0000_0000 && k == 0) check(r, exp0);
         else check(r, k < n && exp0 === 32'h0000_0000 ? fr({DEV, ch, lat[ch*12+:12], 1'b1}) : 32'h0000_0000);
      end
      crs_host_i.close();
      wait_conv();
   endtask
   task automatic t_modes();
      logic [7:0] cb [4] = '{8'h00, 8'h50, 8'hA0, 8'h30};
      int cnt [4] = '{12, 9, 6, 0};
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 12; c++) adc[c*12+:12] = 12'(m * 256 + c * 16 + 5);
         crs_host_i.wr_frame(wr(DEV, crs_pkg::REG_CTRL_HI, cb[m], 1'b0));
         wait_conv();
         lat = adc;
         adc = ~adc;
         check(32'(control_hi), 32'(cb[m]));
         read_n(cnt[m], 32'h0000_0000);
      end
      $display("test modes done");
   endtask
   task automatic t_reg();
      crs_host_i.wr_frame(wr(DEV, crs_pkg::REG_READ, {crs_pkg::REG_CTRL_HI, 2'b00}, 1'b0));
      check(32'(read_addr), 32'(crs_pkg::REG_CTRL_HI));
      wait_conv();
      read_n(0, 32'h0000_0000);
      crs_host_i.wr_frame(wr(DEV, crs_pkg::REG_CTRL_HI, 8'hC0, 1'b0));
      wait_conv();
      read_n(1, fr({DEV, crs_pkg::REG_CTRL_HI, 8'hC0, 3'b001}));
      crs_host_i.wr_frame(wr(DEV, crs_pkg::REG_READ, {crs_pkg::REG_READ, 2'b00}, 1'b0));
      wait_conv();
      read_n(1, fr({DEV, crs_pkg::REG_READ, crs_pkg::REG_READ, 5'b00001}));
      crs_host_i.wr_frame(wr(5'h00, crs_pkg::REG_READ, 8'h00, 1'b1));
      check(32'(read_addr), 32'h0000_0000);
      wait_conv();
      $display("test register read done");
   endtask
   task automatic t_refuse();
      int e;
      e = crc_errs;
      crs_host_i.wr_frame(wr(5'h03, crs_pkg::REG_CTRL_HI, 8'h50, 1'b0));
      crs_host_i.wr_frame(wr(DEV, crs_pkg::REG_CTRL_HI, 8'h50, 1'b0) ^ 32'h0000_0008);
      check(32'(control_hi), 32'h0000_00C0);
      check(32'(crc_errs - e), 32'h0000_0001);
      crs_host_i.wr_frame(wr(5'h00, crs_pkg::REG_CTRL_HI, 8'hA0, 1'b1));
      check(32'(control_hi), 32'h0000_00A0);
      wait_conv();
      crs_host_i.start();
      check(32'(conv_busy), 32'h0000_0001);
      wait_conv();
      $display("test refusals done");
   endtask
   initial begin
      rstn = 1'b0;
      adc = {12{12'h000}};
      lat = adc;
      repeat (8) @(negedge core_clk);
      check(32'({read_addr, control_hi, sdo}), 32'h0000_0000);
      rstn = 1'b1;
      repeat (8) @(negedge core_clk);
      t_modes();
      t_reg();
      t_refuse();
      print_verdict();
   end
endmodule
`default_nettype wire
